//--- src/wdt_consts.svh
// constants for the windowed watchdog supervisor
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_PERIOD_DEFAULT  32'd4096
`define WDT_CNT_W           16
`define WDT_WINDOW_DIV      2
`define WDT_SWEN_BIT        5
`define WDT_WINDOW_DISABLE_FUSE_BIT      6
`define WDT_ONE             16'h0001
`define WDT_ZERO            16'h0000
`endif

//--- src/wdt_pkg.sv
// types for the windowed watchdog supervisor
package wdt_pkg;
	typedef enum logic [1:0] {
		ST_OFF,
		ST_RUN,
		ST_FIRE
	} wdt_state_t;
endpackage

//--- src/windowed_watchdog_control.sv
// windowed watchdog counter with fuse and software enable
`timescale 1ns/1ps
`include "wdt_consts.svh"
module windowed_watchdog_control #(
	parameter int PERIOD = `WDT_PERIOD_DEFAULT
) (
	// clock and device reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// configuration word one and enable fuse
	input  wire logic [15:0] CONFIG_WORD_ONE,
	input  wire logic        WATCHDOG_ENABLE_FUSE,
	// software side
	input  wire logic        WATCHDOG_CLEAR_INSTRUCTION,
	input  wire logic        SWEN_WRITE,
	input  wire logic        SWEN_WDATA,
	// status
	output logic             SOFTWARE_WATCHDOG_ENABLE,
	output logic             WINDOWED_MODE,
	output logic             WATCHDOG_RESET,
	output logic [15:0]      WATCHDOG_COUNTER
);
	localparam logic [15:0] LAST = 16'(PERIOD - `WDT_ONE);
	// window opens at the last quarter: a right shift keeps it a plain cut
	localparam logic [15:0] OPEN = 16'(PERIOD - (PERIOD >> `WDT_WINDOW_DIV));

	logic                 swen_reg, swen_next;
	logic [15:0]          cnt_reg, cnt_next;
	logic                 fire_reg, fire_next;
	wdt_pkg::wdt_state_t  state_reg, state_next;
	logic                 running, windowed, in_window, early;
	logic                 mode_reg, mode_next;

	always_comb begin
		windowed  = ~CONFIG_WORD_ONE[`WDT_WINDOW_DISABLE_FUSE_BIT];
		running   = WATCHDOG_ENABLE_FUSE | swen_reg;
		in_window = cnt_reg >= OPEN;
		early     = windowed & ~in_window;
		swen_next = swen_reg;
		if (SWEN_WRITE) begin
			swen_next = SWEN_WDATA;
		end
		cnt_next   = cnt_reg;
		fire_next  = 1'b0;
		state_next = state_reg;
		case (state_reg)
			wdt_pkg::ST_OFF: begin
				cnt_next = `WDT_ZERO;
				if (running) begin
					state_next = wdt_pkg::ST_RUN;
				end
			end
			wdt_pkg::ST_RUN: begin
				if (!running) begin
					state_next = wdt_pkg::ST_OFF;
					cnt_next   = `WDT_ZERO;
				end else if (WATCHDOG_CLEAR_INSTRUCTION && early) begin
					state_next = wdt_pkg::ST_FIRE;
					fire_next  = 1'b1;
				end else if (WATCHDOG_CLEAR_INSTRUCTION) begin
					cnt_next = `WDT_ZERO;
				end else if (cnt_reg >= LAST) begin
					state_next = wdt_pkg::ST_FIRE;
					fire_next  = 1'b1;
				end else begin
					cnt_next = cnt_reg + `WDT_ONE;
				end
			end
			wdt_pkg::ST_FIRE: begin
				// reset pulse stands until the system reasserts RST
				fire_next = 1'b1;
			end
			default: begin
				state_next = wdt_pkg::ST_OFF;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			swen_reg  <= 1'b0;
			cnt_reg   <= `WDT_ZERO;
			fire_reg  <= 1'b0;
			state_reg <= wdt_pkg::ST_OFF;
		end else begin
			swen_reg  <= swen_next;
			cnt_reg   <= cnt_next;
			fire_reg  <= fire_next;
			state_reg <= state_next;
		end
	end

	assign SOFTWARE_WATCHDOG_ENABLE = swen_reg;
	// status pin is registered; the clear decision uses the live bit so an
	// early clear is judged in the same cycle it arrives
	always_comb begin
		mode_next = ~CONFIG_WORD_ONE[`WDT_WINDOW_DISABLE_FUSE_BIT];
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			mode_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
		end
	end

	assign WINDOWED_MODE            = mode_reg;
	assign WATCHDOG_RESET           = fire_reg;
	assign WATCHDOG_COUNTER         = cnt_reg;

	sequence s_clear_taken;
		state_reg == wdt_pkg::ST_RUN && running && WATCHDOG_CLEAR_INSTRUCTION;
	endsequence

	sequence s_window_closed;
		!CONFIG_WORD_ONE[`WDT_WINDOW_DISABLE_FUSE_BIT] && cnt_reg < OPEN;
	endsequence

	sequence s_window_open;
		CONFIG_WORD_ONE[`WDT_WINDOW_DISABLE_FUSE_BIT] || cnt_reg >= OPEN;
	endsequence

	sequence s_fired;
		WATCHDOG_RESET;
	endsequence

	a_early_seq: assert property (@(posedge CLK) disable iff (RST)
		s_clear_taken ##0 s_window_closed |=> s_fired)
		else $error("early clear did not fire");

	a_open_seq: assert property (@(posedge CLK) disable iff (RST)
		s_clear_taken ##0 s_window_open |=> cnt_reg == `WDT_ZERO)
		else $error("open window clear not taken");

	a_fire_sticky: assert property (@(posedge CLK) disable iff (RST)
		s_fired |=> s_fired)
		else $error("watchdog reset dropped early");

	a_fire_state: assert property (@(posedge CLK) disable iff (RST)
		WATCHDOG_RESET |-> state_reg == wdt_pkg::ST_FIRE)
		else $error("reset out without fire state");

	a_run_quiet: assert property (@(posedge CLK) disable iff (RST)
		state_reg == wdt_pkg::ST_RUN |-> !WATCHDOG_RESET)
		else $error("reset out while running");

	a_cnt_bound: assert property (@(posedge CLK) disable iff (RST)
		cnt_reg <= LAST)
		else $error("counter passed period");

	a_off_zero: assert property (@(posedge CLK) disable iff (RST)
		state_reg == wdt_pkg::ST_OFF |-> cnt_reg == `WDT_ZERO)
		else $error("counter moved while off");

	a_swen_write: assert property (@(posedge CLK) disable iff (RST)
		SWEN_WRITE |=> swen_reg == $past(SWEN_WDATA))
		else $error("soft enable write lost");

	a_swen_hold: assert property (@(posedge CLK) disable iff (RST)
		!SWEN_WRITE |=> $stable(swen_reg))
		else $error("soft enable changed unasked");

	a_idle_quiet: assert property (@(posedge CLK) disable iff (RST)
		state_reg == wdt_pkg::ST_OFF && !WATCHDOG_RESET |=> !WATCHDOG_RESET)
		else $error("reset out while disabled");

	a_swen_reset: assert property (@(posedge CLK)
		RST |=> !swen_reg) else $error("soft enable not cleared");
	a_fuse_runs: assert property (@(posedge CLK) disable iff (RST)
		WATCHDOG_ENABLE_FUSE && state_reg == wdt_pkg::ST_OFF
		|=> state_reg == wdt_pkg::ST_RUN)
		else $error("fuse did not start watchdog");
	a_off_idle: assert property (@(posedge CLK) disable iff (RST)
		!WATCHDOG_ENABLE_FUSE && !swen_reg && state_reg == wdt_pkg::ST_RUN
		|=> state_reg == wdt_pkg::ST_OFF)
		else $error("watchdog ran while disabled");
	a_early_fire: assert property (@(posedge CLK) disable iff (RST)
		state_reg == wdt_pkg::ST_RUN && running && WATCHDOG_CLEAR_INSTRUCTION
		&& !CONFIG_WORD_ONE[`WDT_WINDOW_DISABLE_FUSE_BIT] && cnt_reg < OPEN
		|=> WATCHDOG_RESET) else $error("early clear not punished");
	a_late_clear: assert property (@(posedge CLK) disable iff (RST)
		state_reg == wdt_pkg::ST_RUN && running && WATCHDOG_CLEAR_INSTRUCTION
		&& (CONFIG_WORD_ONE[`WDT_WINDOW_DISABLE_FUSE_BIT] || cnt_reg >= OPEN)
		|=> cnt_reg == `WDT_ZERO && !WATCHDOG_RESET)
		else $error("valid clear not accepted");
	a_timeout: assert property (@(posedge CLK) disable iff (RST)
		state_reg == wdt_pkg::ST_RUN && running && !WATCHDOG_CLEAR_INSTRUCTION
		&& cnt_reg >= LAST |=> WATCHDOG_RESET)
		else $error("time-out missed");
	a_count_up: assert property (@(posedge CLK) disable iff (RST)
		state_reg == wdt_pkg::ST_RUN && running && !WATCHDOG_CLEAR_INSTRUCTION
		&& cnt_reg < LAST |=> cnt_reg == $past(cnt_reg) + `WDT_ONE)
		else $error("counter did not advance");
	a_mode_sel: assert property (@(posedge CLK) disable iff (RST)
		1'b1 |=> WINDOWED_MODE == !$past(CONFIG_WORD_ONE[`WDT_WINDOW_DISABLE_FUSE_BIT]))
		else $error("window mode mismatch");
endmodule // windowed_watchdog_control

//--- tb/windowed_watchdog_control_bench.sv
// self-checking bench for the windowed watchdog supervisor
`timescale 1ns/1ps
module windowed_watchdog_control_bench;
	localparam int P = 16;
	logic        clk = 0, rst = 1, fuse = 0, clr = 0, swr = 0, swd = 0;
	logic [15:0] cfg = 16'h0000, cnt;
	logic        swen, win, wrst;
	int          mismatches = 0, comparisons = 0, i, n;
	windowed_watchdog_control #(.PERIOD(P)) DUT (.CLK(clk), .RST(rst),
		.CONFIG_WORD_ONE(cfg), .WATCHDOG_ENABLE_FUSE(fuse),
		.WATCHDOG_CLEAR_INSTRUCTION(clr), .SWEN_WRITE(swr),
		.SWEN_WDATA(swd), .SOFTWARE_WATCHDOG_ENABLE(swen),
		.WINDOWED_MODE(win), .WATCHDOG_RESET(wrst),
		.WATCHDOG_COUNTER(cnt));
	initial forever #25 clk = ~clk;
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic do_reset();
		rst = 1;
		repeat (3) @(negedge clk);
		rst = 0;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		@(negedge clk);
		s = 0;
	endtask
	// bounded wait; a hang is a mismatch and closes the run
	task automatic wait_fire(input int lim);
		for (i = 0; i < lim && wrst !== 1'b1; i++) @(negedge clk);
		if (i == lim) begin
			chk(1'b0, "no watchdog reset");
			complete_run();
		end
	endtask
	initial begin
		i = $urandom(85032);
		do_reset();
		chk(swen === 1'b0 && cnt === 16'h0000 && wrst === 1'b0, "rst");
		cfg = 16'($urandom) | 16'h0040;
		fuse = 1;
		@(negedge clk);
		chk(win === 1'b0, "mode off");
		wait_fire(P + 3);
		chk(i == P, "timeout cycle");
		$display("test fuse timeout done");
		fuse = 0;
		do_reset();
		repeat (P + 4) @(negedge clk);
		chk(wrst === 1'b0 && cnt === 16'h0000, "ran disabled");
		cfg = 16'($urandom) & 16'hFFBF;
		swd = 1;
		pulse(swr);
		chk(swen === 1'b1 && win === 1'b1, "enable");
		// stays clear of the window, which opens at count 12
		n = $urandom_range(8, 0);
		repeat (n + 1) @(negedge clk);
		pulse(clr);
		wait_fire(3);
		$display("test early clear done");
		do_reset();
		chk(swen === 1'b0 && wrst === 1'b0, "swen kept");
		pulse(swr);
		for (i = 0; i < P && cnt !== 16'(P - 2); i++) @(negedge clk);
		if (i == P) begin
			chk(1'b0, "window never reached");
			complete_run();
		end
		pulse(clr);
		repeat (2) @(negedge clk);
		chk(wrst === 1'b0 && cnt < 16'h0004, "late clear");
		$display("test late clear done");
		swd = 0;
		pulse(swr);
		repeat (2) @(negedge clk);
		chk(swen === 1'b0 && cnt === 16'h0000 && wrst === 1'b0, "off");
		$display("test soft disable done");
		complete_run();
	end
endmodule // windowed_watchdog_control_bench
